// *** src/lpb_cfg.svh ***
`ifndef LPB_CFG_SVH
`define LPB_CFG_SVH

// core clock period and oscillator stabilization time
`define LPB_CLK_NS        10
`define LPB_OSC_STAB_NS   40960
`define LPB_OSC_STAB_CYC  ((`LPB_OSC_STAB_NS + `LPB_CLK_NS - 1) / `LPB_CLK_NS)
`define LPB_DLY_W         13

// break vector pairs, high byte address of each pair
`define LPB_VEC_BRK_NORM  16'hFFFC
`define LPB_VEC_BRK_MON   16'hFEFC

// interrupt mask value after any reset
`define LPB_IMASK_RST     1'h1

`endif

// *** src/lpb_pkg.sv ***
package lpb_pkg;

	typedef enum logic [2:0] {
		LPB_RUN  = 3'h0,
		LPB_WAIT = 3'h1,
		LPB_STOP = 3'h2,
		LPB_STAB = 3'h3
	} lpb_state_t;

endpackage

// *** src/lpb_dly_if.sv ***
interface lpb_dly_if;
	logic start;
	logic busy;
	logic done;

	modport ctl (output start, input busy, input done);
	modport tmr (input start, output busy, output done);
endinterface

// *** src/lpb_osc_dly.sv ***
`include "lpb_cfg.svh"

module lpb_osc_dly import lpb_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// delay handshake
	lpb_dly_if.tmr   dly
);

	logic [`LPB_DLY_W-1:0] cnt_r;
	logic [`LPB_DLY_W-1:0] cnt_nxt;
	logic                  busy_r;
	logic                  busy_nxt;
	logic                  last_w;

	assign last_w   = busy_r && (cnt_r == `LPB_DLY_W'(1));
	// a start while counting restarts the full period
	assign cnt_nxt  = dly.start ? `LPB_DLY_W'(`LPB_OSC_STAB_CYC) :
	                  busy_r    ? cnt_r - `LPB_DLY_W'(1) : cnt_r;
	assign busy_nxt = dly.start | (busy_r & ~last_w);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign dly.busy = busy_r;
	assign dly.done = last_w & ~dly.start;

endmodule

// *** src/lpb_ctrl.sv ***
//
// Functional notes
// - wait clears interrupt mask, halts core clock
// - wait exit: irq keeps mask clear, reset sets
// - stop clears interrupt mask, halts core clock
// - stop exit: irq keeps mask clear, reset sets
// - core clock waits full oscillator stabilization delay on irq stop exit; reset exit resumes at once
// - break forces software_interrupt_instr into instruction register
// - break vector FFFC, or FEFC in monitor
// - break only at instruction boundary
// - match on last cycle starts break at once
// - return ends break once request is dropped
// - mask set ignores maskable requests
// - return restores mask from stacked value
//
`include "lpb_cfg.svh"

module lpb_ctrl import lpb_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// core sequencing, sampled on the last cycle of an instruction except sys_reset_req and int_stacked, which act in any cycle
	input  wire logic        instr_done,
	input  wire logic        exec_wait,
	input  wire logic        exec_stop,
	input  wire logic        exec_rti,
	input  wire logic        rti_stacked_imask,
	input  wire logic        int_stacked,
	input  wire logic        monitor_mode,
	input  wire logic        sys_reset_req,
	// interrupt sources
	input  wire logic        irq_req,
	input  wire logic        ext_irq,
	// break module
	input  wire logic        brk_req,
	// core control
	output logic             core_clk_en,
	output logic             imask,
	output logic             irq_take,
	output logic             brk_start,
	output logic             ir_load_swi,
	output logic             pc_load_vec,
	output logic             brk_active,
	output logic [15:0]      brk_vector,
	output lpb_state_t       mode
);

	////////////////////////////////////////////////////////////////////////
	// state

	lpb_state_t  state_r;
	lpb_state_t  state_nxt;
	logic        imask_r;
	logic        imask_nxt;
	logic        brk_pend_r;
	logic        brk_pend_nxt;
	logic        brk_act_r;
	logic        brk_act_nxt;
	logic [15:0] vec_r;
	logic [15:0] vec_nxt;

	lpb_dly_if dly ();

	lpb_osc_dly u_dly (
		.clk   (clk),
		.rst_n (rst_n),
		.dly   (dly.tmr)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	wire run_w      = (state_r == LPB_RUN);
	wire boundary_w = run_w & instr_done;
	wire do_wait_w  = boundary_w & exec_wait & ~brk_start;
	wire do_stop_w  = boundary_w & exec_stop & ~brk_start;
	wire do_rti_w   = boundary_w & exec_rti;
	// a request in the final cycle counts without waiting for the latch
	wire brk_seen_w = (brk_req | brk_pend_r) & ~brk_act_r;
	wire brk_go_w   = boundary_w & brk_seen_w;
	wire irq_ok_w   = irq_req & ~imask_r;
	wire wait_wake  = (state_r == LPB_WAIT) & irq_ok_w;
	wire stop_wake  = (state_r == LPB_STOP) & ext_irq;
	// the timer runs on after a reset abort; its done only counts while stabilising
	wire stab_done_w = (state_r == LPB_STAB) & dly.done;

	assign brk_start   = brk_go_w & ~sys_reset_req;
	assign ir_load_swi = brk_start;
	assign pc_load_vec = brk_start;
	// break outranks maskable interrupts at the same boundary
	assign irq_take    = ~sys_reset_req & ((boundary_w & irq_ok_w & ~brk_go_w)
	                   | wait_wake | stab_done_w);
	assign dly.start   = stop_wake & ~sys_reset_req;

	// the gate is only a decode of the clocked state; detection stays on clk
	assign core_clk_en = run_w;
	assign imask       = imask_r;
	assign brk_active  = brk_act_r;
	assign brk_vector  = vec_r;
	assign mode        = state_r;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			LPB_RUN: begin
				if (do_wait_w) begin
					state_nxt = LPB_WAIT;
				end else if (do_stop_w) begin
					state_nxt = LPB_STOP;
				end
			end
			LPB_WAIT: begin
				if (wait_wake) begin
					state_nxt = LPB_RUN;
				end
			end
			LPB_STOP: begin
				if (stop_wake) begin
					state_nxt = LPB_STAB;
				end
			end
			LPB_STAB: begin
				if (dly.done) begin
					state_nxt = LPB_RUN;
				end
			end
			default: begin
				state_nxt = LPB_RUN;
			end
		endcase
		if (sys_reset_req) begin
			state_nxt = LPB_RUN;
		end
	end

	// mask: reset sets it; stacking on entry sets it; return and standby write it
	assign imask_nxt = sys_reset_req            ? `LPB_IMASK_RST :
	                   int_stacked              ? 1'b1 :
	                   do_rti_w                 ? rti_stacked_imask :
	                   (do_wait_w | do_stop_w)  ? 1'b0 : imask_r;

	assign brk_pend_nxt = sys_reset_req ? 1'b0 :
	                      brk_start     ? 1'b0 :
	                      (brk_pend_r | (brk_req & ~brk_act_r));

	// the break stays in force while the break module still requests it
	assign brk_act_nxt = sys_reset_req              ? 1'b0 :
	                     brk_start                  ? 1'b1 :
	                     (do_rti_w & ~brk_req)      ? 1'b0 : brk_act_r;

	assign vec_nxt = brk_start ? (monitor_mode ? `LPB_VEC_BRK_MON
	                                           : `LPB_VEC_BRK_NORM) : vec_r;

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r    <= LPB_RUN;
			imask_r    <= `LPB_IMASK_RST;
			brk_pend_r <= 1'b0;
			brk_act_r  <= 1'b0;
			vec_r      <= `LPB_VEC_BRK_NORM;
		end else begin
			state_r    <= state_nxt;
			imask_r    <= imask_nxt;
			brk_pend_r <= brk_pend_nxt;
			brk_act_r  <= brk_act_nxt;
			vec_r      <= vec_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_wait_entry;
		(do_wait_w && !sys_reset_req && !int_stacked)
			|=> (!imask && !core_clk_en && mode == LPB_WAIT);
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");

	property p_wait_exit_irq;
		(state_r == LPB_WAIT && irq_req && !sys_reset_req && !int_stacked)
			|-> irq_take ##1 (!imask && core_clk_en);
	endproperty
	a_wait_exit_irq: assert property (p_wait_exit_irq) else $error("wait wake lost mask");

	property p_reset_sets_mask;
		sys_reset_req |=> (imask && mode == LPB_RUN && !brk_active);
	endproperty
	a_reset_sets_mask: assert property (p_reset_sets_mask) else $error("reset kept mask clear");

	property p_stop_entry;
		(do_stop_w && !sys_reset_req && !int_stacked)
			|=> (!imask && !core_clk_en && mode == LPB_STOP);
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");

	property p_stop_exit_mask;
		(stop_wake && !sys_reset_req) ##1 (!sys_reset_req && !int_stacked)[*8]
			|-> !imask;
	endproperty
	a_stop_exit_mask: assert property (p_stop_exit_mask) else $error("stop wake set mask");

	// cycles spent stabilising, checked against the full delay
	logic [`LPB_DLY_W:0] stab_cnt_r;
	always_ff @(posedge clk) begin
		if (!rst_n || state_r != LPB_STAB) begin
			stab_cnt_r <= '0;
		end else begin
			stab_cnt_r <= stab_cnt_r + (`LPB_DLY_W+1)'(1);
		end
	end

	property p_stab_full;
		(state_r == LPB_STAB && state_nxt == LPB_RUN && !sys_reset_req)
			|-> (stab_cnt_r == (`LPB_DLY_W+1)'(`LPB_OSC_STAB_CYC - 1));
	endproperty
	a_stab_full: assert property (p_stab_full) else $error("clock resumed early");

	property p_no_clk_in_stab;
		(state_r == LPB_STAB) |-> !core_clk_en;
	endproperty
	a_no_clk_in_stab: assert property (p_no_clk_in_stab) else $error("clock ran in delay");

	property p_stab_busy;
		(state_r == LPB_STAB) |-> dly.busy;
	endproperty
	a_stab_busy: assert property (p_stab_busy) else $error("delay timer idle while stabilising");

	property p_brk_swi;
		brk_start |-> (ir_load_swi && pc_load_vec && instr_done && core_clk_en);
	endproperty
	a_brk_swi: assert property (p_brk_swi) else $error("break not at boundary");

	property p_brk_vec;
		brk_start |=> (brk_active && brk_vector ==
			($past(monitor_mode) ? `LPB_VEC_BRK_MON : `LPB_VEC_BRK_NORM));
	endproperty
	a_brk_vec: assert property (p_brk_vec) else $error("break vector wrong");

	property p_brk_immediate;
		(run_w && instr_done && brk_req && !brk_active && !sys_reset_req) |-> brk_start;
	endproperty
	a_brk_immediate: assert property (p_brk_immediate) else $error("break delayed");

	property p_brk_end;
		(brk_active && do_rti_w && !brk_start && !sys_reset_req)
			|=> (brk_active == $past(brk_req));
	endproperty
	a_brk_end: assert property (p_brk_end) else $error("break end wrong");

	property p_masked_ignored;
		(imask && run_w) |-> !irq_take;
	endproperty
	a_masked_ignored: assert property (p_masked_ignored) else $error("masked irq taken");

	property p_rti_mask;
		(do_rti_w && !sys_reset_req && !int_stacked) |=> (imask == $past(rti_stacked_imask));
	endproperty
	a_rti_mask: assert property (p_rti_mask) else $error("mask not restored");

	c_wait_wake: cover property (state_r == LPB_WAIT ##1 state_r == LPB_RUN);
	c_stop_wake: cover property (state_r == LPB_STAB ##1 state_r == LPB_RUN);
	c_brk_round: cover property (brk_start ##[1:50] (brk_active && do_rti_w && !brk_req));
	c_brk_mon:   cover property (brk_start && monitor_mode);

endmodule

// *** test/lpb_src_model.sv ***
module lpb_src_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// bench controls
	input  wire logic brk_hit,
	input  wire logic brk_clr,
	input  wire logic irq_want,
	input  wire logic ext_want,
	// requests toward the core
	output logic      brk_req,
	output logic      irq_req,
	output logic      ext_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// a match stays asserted until the break routine clears it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			brk_req <= 1'h0;
			irq_req <= 1'h0;
			ext_irq <= 1'h0;
		end else begin
			brk_req <= brk_hit | (brk_req & ~brk_clr);
			irq_req <= irq_want;
			ext_irq <= ext_want;
		end
	end
endmodule

// *** test/lpb_ctrl_tb.sv ***
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	$display("[ERR] %s exp %h got %h", nm, e, g); n_mismatch++; end end

module lpb_ctrl_tb import lpb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'h0, rst_n = 1'h0;
	logic instr_done = 1'h0, exec_wait = 1'h0, exec_stop = 1'h0, exec_rti = 1'h0;
	logic rti_stacked_imask = 1'h0, int_stacked = 1'h0, monitor_mode = 1'h0;
	logic sys_reset_req = 1'h0, brk_hit = 1'h0, brk_clr = 1'h0;
	logic irq_want = 1'h0, ext_want = 1'h0;
	logic irq_req, ext_irq, brk_req, core_clk_en, imask, irq_take;
	logic brk_start, ir_load_swi, pc_load_vec, brk_active;
	logic [15:0] brk_vector;
	lpb_state_t mode;
	int n_mismatch = 0, n_checks = 0;

	always #5 clk = ~clk;

	lpb_src_model src (.clk(clk), .rst_n(rst_n), .brk_hit(brk_hit), .brk_clr(brk_clr),
		.irq_want(irq_want), .ext_want(ext_want), .brk_req(brk_req),
		.irq_req(irq_req), .ext_irq(ext_irq));

	lpb_ctrl dut (.clk(clk), .rst_n(rst_n), .instr_done(instr_done),
		.exec_wait(exec_wait), .exec_stop(exec_stop), .exec_rti(exec_rti),
		.rti_stacked_imask(rti_stacked_imask), .int_stacked(int_stacked),
		.monitor_mode(monitor_mode), .sys_reset_req(sys_reset_req), .irq_req(irq_req),
		.ext_irq(ext_irq), .brk_req(brk_req), .core_clk_en(core_clk_en), .imask(imask),
		.irq_take(irq_take), .brk_start(brk_start), .ir_load_swi(ir_load_swi),
		.pc_load_vec(pc_load_vec), .brk_active(brk_active), .brk_vector(brk_vector),
		.mode(mode));

	task automatic finish_test;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic nx;
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		`CHK("vector", 16'hFFFC, brk_vector)
		irq_want = 1'h1;
		nx();
		nx();
		instr_done = 1'h1;
		#1 `CHK("irq_take", 1'h0, irq_take)
		nx();
		instr_done = 1'h0;
		irq_want = 1'h0;
	endtask

	task automatic t_wait(input logic by_rst);
		instr_done = 1'h1;
		exec_wait = 1'h1;
		nx();
		instr_done = 1'h0;
		exec_wait = 1'h0;
		`CHK("mode", LPB_WAIT, mode)
		`CHK("clk_en", 1'h0, core_clk_en)
		`CHK("imask", 1'h0, imask)
		sys_reset_req = by_rst;
		irq_want = ~by_rst;
		nx();
		sys_reset_req = 1'h0;
		if (!by_rst) begin
			#1 `CHK("irq_take", 1'h1, irq_take)
			nx();
			irq_want = 1'h0;
			instr_done = 1'h1;
			#1 `CHK("irq_take", 1'h1, irq_take)
			nx();
			instr_done = 1'h0;
		end
		`CHK("mode", LPB_RUN, mode)
		`CHK("imask", by_rst, imask)
		int_stacked = 1'h1;
		nx();
		int_stacked = 1'h0;
	endtask

	// irq_req must not wake stop; only the external line does
	task automatic t_stop(input logic by_rst);
		int n, tk;
		instr_done = 1'h1;
		exec_stop = 1'h1;
		nx();
		instr_done = 1'h0;
		exec_stop = 1'h0;
		`CHK("mode", LPB_STOP, mode)
		`CHK("imask", 1'h0, imask)
		irq_want = 1'h1;
		repeat (3) nx();
		irq_want = 1'h0;
		`CHK("clk_en", 1'h0, core_clk_en)
		sys_reset_req = by_rst;
		ext_want = ~by_rst;
		nx();
		sys_reset_req = 1'h0;
		ext_want = 1'h0;
		if (!by_rst) begin
			nx();
			n = 0;
			tk = -1;
			while (mode !== LPB_RUN && n < 5000) begin
				if (irq_take === 1'h1) tk = n;
				n++;
				nx();
			end
			if (n == 5000) begin
				n_mismatch++;
				finish_test();
			end
			`CHK("stab_len", 4096, n)
			`CHK("wake_irq", 4095, tk)
		end
		`CHK("mode", LPB_RUN, mode)
		`CHK("imask", by_rst, imask)
		`CHK("clk_en", 1'h1, core_clk_en)
	endtask

	// reset in the delay must not leave a late wake pulse behind
	task automatic t_stab_rst;
		int n, hits;
		instr_done = 1'h1;
		exec_stop = 1'h1;
		nx();
		instr_done = 1'h0;
		exec_stop = 1'h0;
		ext_want = 1'h1;
		nx();
		ext_want = 1'h0;
		repeat (4) nx();
		`CHK("mode", LPB_STAB, mode)
		sys_reset_req = 1'h1;
		nx();
		sys_reset_req = 1'h0;
		`CHK("mode", LPB_RUN, mode)
		`CHK("imask", 1'h1, imask)
		hits = 0;
		for (n = 0; n < 4200; n++) begin
			if (irq_take !== 1'h0) hits++;
			nx();
		end
		`CHK("late_take", 0, hits)
	endtask

	// reset from standby in mid-run, with the monitor vector left behind
	task automatic t_hard_rst;
		instr_done = 1'h1;
		exec_wait = 1'h1;
		nx();
		instr_done = 1'h0;
		exec_wait = 1'h0;
		rst_n = 1'h0;
		repeat (2) nx();
		rst_n = 1'h1;
		`CHK("mode", LPB_RUN, mode)
		`CHK("imask", 1'h1, imask)
		`CHK("clk_en", 1'h1, core_clk_en)
		`CHK("active", 1'h0, brk_active)
		`CHK("vector", 16'hFFFC, brk_vector)
		repeat (2) nx();
	endtask

	task automatic t_brk(input logic mon, input logic last);
		monitor_mode = mon;
		brk_hit = 1'h1;
		nx();
		brk_hit = 1'h0;
		if (!last) begin
			#1 `CHK("brk_start", 1'h0, brk_start)
			nx();
		end
		instr_done = 1'h1;
		#1 `CHK("brk_start", 1'h1, brk_start)
		`CHK("ir_swi", 1'h1, ir_load_swi)
		`CHK("pc_load", 1'h1, pc_load_vec)
		nx();
		`CHK("vector", mon ? 16'hFEFC : 16'hFFFC, brk_vector)
		`CHK("active", 1'h1, brk_active)
		exec_rti = 1'h1;
		nx();
		instr_done = 1'h0;
		exec_rti = 1'h0;
		`CHK("active", 1'h1, brk_active)
		`CHK("imask", 1'h0, imask)
		brk_clr = 1'h1;
		nx();
		brk_clr = 1'h0;
		nx();
		instr_done = 1'h1;
		exec_rti = 1'h1;
		rti_stacked_imask = 1'h1;
		nx();
		instr_done = 1'h0;
		exec_rti = 1'h0;
		rti_stacked_imask = 1'h0;
		`CHK("active", 1'h0, brk_active)
		`CHK("imask", 1'h1, imask)
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) nx();
		rst_n = 1'h1;
		t_reset();
		t_wait(1'h0);
		t_wait(1'h1);
		t_stop(1'h1);
		t_stop(1'h0);
		t_stab_rst();
		t_brk(1'h0, 1'h0);
		t_brk(1'h1, 1'h1);
		t_hard_rst();
		finish_test();
	end
endmodule
